// [hdl/ddc_cmd_readback.v]
// serial command decoder, double-buffered registers and rolling readback for a dual dac
`timescale 1ns/1ps
`include "ddc_defs.vh"
module ddc_cmd_readback #(
    parameter DW = 16,
    parameter SW = 4
) (
    input wire clk_i,                   // 20 MHz system clock
    input wire rst_i,                   // synchronous reset, active high
    input wire link_clk_i,              // serial clock pin from host
    input wire serial_in_i,             // serial data pin from host
    input wire select_and_load_n_i,     // frame select, rising edge loads
    input wire async_update_n_i,        // asynchronous update-all pin
    input wire clear_n_i,               // system clear pin
    input wire manual_span_i,           // high selects strap-pin span
    input wire span_strap_bit2_i,       // span strap pin 2
    input wire span_strap_bit1_i,       // span strap pin 1
    input wire span_strap_bit0_i,       // span strap pin 0
    output wire readback_serial_out_o,  // readback data bit
    output wire readback_serial_oe_o,   // readback pin driven when high
    output wire [DW-1:0] act_code_a_o,  // channel a code in force
    output wire [DW-1:0] act_code_b_o,  // channel b code in force
    output wire [SW-1:0] act_span_a_o,  // channel a span in force
    output wire [SW-1:0] act_span_b_o,  // channel b span in force
    output wire [1:0] span_bipolar_o,   // per channel, span is bipolar
    output wire [1:0] span_legal_o      // per channel, span code defined
);

    // ****************************************************************
    // functions
    // ****************************************************************

    // channel whose register is read back; both-channel address reads a
    function rb_chan;
        input [3:0] addr;
        begin
            rb_chan = (addr[3:1] == `DDC_ADDR_B);
        end
    endfunction

    // channel hit for writes and updates
    function chan_hit;
        input [3:0] addr;
        input ch;
        begin
            chan_hit = (addr[3:1] == `DDC_ADDR_ALL) ||
                       (ch ? (addr[3:1] == `DDC_ADDR_B) : (addr[3:1] == `DDC_ADDR_A));
        end
    endfunction

    // pick the buffer named by a readback pointer
    function [DW-1:0] rb_pick;
        input [2:0] p;
        input [2*SW-1:0] ispan;
        input [2*DW-1:0] icode;
        input [2*SW-1:0] aspan;
        input [2*DW-1:0] acode;
        begin
            case (p[1:0])
                `DDC_SEL_IN_SPAN: rb_pick = {{(DW-SW){1'b0}}, ispan[p[2]*SW +: SW]};
                `DDC_SEL_IN_CODE: rb_pick = icode[p[2]*DW +: DW];
                `DDC_SEL_ACT_SPAN: rb_pick = {{(DW-SW){1'b0}}, aspan[p[2]*SW +: SW]};
                default: rb_pick = acode[p[2]*DW +: DW];
            endcase
        end
    endfunction

    // span range class: {legal, bipolar}
    function [1:0] span_class;
        input [SW-1:0] s;
        begin
            case (s)
                `DDC_SPAN_UNI_5, `DDC_SPAN_UNI_10: span_class = 2'h2;
                `DDC_SPAN_BI_5, `DDC_SPAN_BI_10, `DDC_SPAN_BI_2P5, `DDC_SPAN_OFS_2P5: span_class = 2'h3;
                default: span_class = 2'h0;
            endcase
        end
    endfunction

    // ****************************************************************
    // pin synchronisation and edge detection
    // ****************************************************************

    wire sck_s;
    wire sdi_s;
    wire cs_n_s;
    wire upd_n_s;
    wire clr_n_s;
    wire mspan_s;
    wire [2:0] strap_s;

    // idle levels at reset: select, update and clear all high
    ddc_sync2 #(
        .W(9),
        .RST_VAL(9'h070)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({link_clk_i, serial_in_i, select_and_load_n_i, async_update_n_i, clear_n_i, manual_span_i,
              span_strap_bit2_i, span_strap_bit1_i, span_strap_bit0_i}),
        .q_o({sck_s, sdi_s, cs_n_s, upd_n_s, clr_n_s, mspan_s, strap_s})
    );

    reg sck_prev_reg;
    reg cs_prev_reg;
    reg upd_prev_reg;

    // previous levels, for edge detection on synchronised pins only
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sck_prev_reg <= 1'b0;
            cs_prev_reg <= 1'b1;
            upd_prev_reg <= 1'b1;
        end
        else
        begin
            sck_prev_reg <= sck_s;
            cs_prev_reg <= cs_n_s;
            upd_prev_reg <= upd_n_s;
        end
    end

    wire in_frame = ~cs_n_s & clr_n_s;
    wire sck_rise = in_frame & sck_s & ~sck_prev_reg;
    wire sck_fall = in_frame & ~sck_s & sck_prev_reg;
    wire frame_end = cs_n_s & ~cs_prev_reg;
    // update pin is locked out while a frame is open
    wire upd_pin_fire = cs_n_s & cs_prev_reg & upd_prev_reg & ~upd_n_s;

    // ****************************************************************
    // frame capture
    // ****************************************************************

    reg [23:0] shin_reg;
    reg [5:0] cnt_reg;
    reg long_reg;
    reg frame_bad_reg;
    reg [2:0] ptr_reg;

    wire [5:0] cnt_next = (cnt_reg == `DDC_CNT_MAX) ? cnt_reg : cnt_reg + 6'h01;
    wire [7:0] new_byte = {shin_reg[6:0], sdi_s};
    wire zero_lead = (cnt_next == `DDC_HDR_BITS) && (new_byte == 8'h00);
    wire hdr_done = sck_rise && ((!long_reg && !zero_lead && cnt_next == `DDC_HDR_BITS) ||
                                 (long_reg && cnt_next == `DDC_LONG_HDR_BITS));
    wire [3:0] hdr_cmd = new_byte[7:4];
    wire [3:0] hdr_addr = new_byte[3:0];
    wire hdr_read = (hdr_cmd >= `DDC_CMD_RD_IN_SPAN) && (hdr_cmd <= `DDC_CMD_RD_ACT_CODE);
    wire [2:0] rd_ptr = {rb_chan(hdr_addr), hdr_cmd[1:0] ^ `DDC_RD_SEL_FLIP};

    // shift in MSB first; a leading zero byte marks the long frame
    always @(posedge clk_i)
    begin
        if (rst_i || !in_frame)
        begin
            shin_reg <= 24'h000000;
            cnt_reg <= 6'h00;
            long_reg <= 1'b0;
        end
        else if (sck_rise)
        begin
            shin_reg <= {shin_reg[22:0], sdi_s};
            cnt_reg <= cnt_next;
            if (zero_lead)
            begin
                long_reg <= 1'b1;
            end
        end
    end

    // a clear during a frame aborts the instruction at its end
    always @(posedge clk_i)
    begin
        if (rst_i || frame_end)
        begin
            frame_bad_reg <= 1'b0;
        end
        else if (!clr_n_s && !cs_n_s)
        begin
            frame_bad_reg <= 1'b1;
        end
    end

    wire [5:0] need_bits = long_reg ? `DDC_LONG_FRAME_BITS : `DDC_SHORT_FRAME_BITS;
    // a short or aborted frame writes and updates nothing
    wire frame_ok = frame_end && clr_n_s && !frame_bad_reg && (cnt_reg >= need_bits);
    wire [3:0] f_cmd = shin_reg[23:20];
    wire [3:0] f_addr = shin_reg[19:16];
    wire [DW-1:0] f_data = shin_reg[15:0];

    wire f_wr_span = (f_cmd == `DDC_CMD_WR_SPAN) || (f_cmd == `DDC_CMD_WRS_UPD_N) ||
                     (f_cmd == `DDC_CMD_WRS_UPD_ALL);
    wire f_wr_code = (f_cmd == `DDC_CMD_WR_CODE) || (f_cmd == `DDC_CMD_WRC_UPD_N) ||
                     (f_cmd == `DDC_CMD_WRC_UPD_ALL);
    wire f_upd_n = (f_cmd == `DDC_CMD_UPD_N) || (f_cmd == `DDC_CMD_WRS_UPD_N) ||
                   (f_cmd == `DDC_CMD_WRC_UPD_N);
    wire f_upd_all = (f_cmd == `DDC_CMD_UPD_ALL) || (f_cmd == `DDC_CMD_WRS_UPD_ALL) ||
                     (f_cmd == `DDC_CMD_WRC_UPD_ALL);

    // ****************************************************************
    // per-channel double-buffered registers
    // ****************************************************************

    wire [2*SW-1:0] in_span_w;
    wire [2*DW-1:0] in_code_w;
    wire [2*SW-1:0] act_span_w;
    wire [2*SW-1:0] act_span_rd;
    wire [2*DW-1:0] act_code_w;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_chan
            reg [SW-1:0] in_span_reg;
            reg [DW-1:0] in_code_reg;
            reg [SW-1:0] act_span_reg;
            reg [DW-1:0] act_code_reg;
            wire hit = chan_hit(f_addr, g == 1);
            wire wr_span = frame_ok && f_wr_span && hit;
            wire wr_code = frame_ok && f_wr_code && hit;
            wire upd = (frame_ok && ((f_upd_n && hit) || f_upd_all)) || upd_pin_fire;
            wire [SW-1:0] span_src = wr_span ? f_data[SW-1:0] : in_span_reg;
            wire [DW-1:0] code_src = wr_code ? f_data : in_code_reg;

            // input buffers survive a clear; only reset empties them
            always @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    in_span_reg <= {SW{1'b0}};
                    in_code_reg <= {DW{1'b0}};
                end
                else
                begin
                    if (wr_span)
                    begin
                        in_span_reg <= f_data[SW-1:0];
                    end
                    if (wr_code)
                    begin
                        in_code_reg <= f_data;
                    end
                end
            end

            // update copies span and code together; write lands first
            always @(posedge clk_i)
            begin
                if (rst_i || !clr_n_s)
                begin
                    act_span_reg <= {SW{1'b0}};
                    act_code_reg <= {DW{1'b0}};
                end
                else if (upd)
                begin
                    act_span_reg <= span_src;
                    act_code_reg <= code_src;
                end
            end

            assign in_span_w[g*SW +: SW] = in_span_reg;
            assign in_code_w[g*DW +: DW] = in_code_reg;
            assign act_span_w[g*SW +: SW] = act_span_reg;
            assign act_code_w[g*DW +: DW] = act_code_reg;
            // in manual mode the straps are the span in force
            assign act_span_rd[g*SW +: SW] = mspan_s ? {1'b0, strap_s} : act_span_reg;
            assign span_bipolar_o[g] = span_class(act_span_rd[g*SW +: SW]) == 2'h3;
            assign span_legal_o[g] = span_class(act_span_rd[g*SW +: SW]) != 2'h0;
        end
    endgenerate

    // ****************************************************************
    // readback pointer
    // ****************************************************************

    reg [2:0] ptr_next;
    reg ptr_set;

    // pointer for the next word, chosen by the completed command
    always @*
    begin
        ptr_set = 1'b1;
        ptr_next = {rb_chan(f_addr), `DDC_SEL_ACT_CODE};
        case (f_cmd)
            `DDC_CMD_WR_SPAN: ptr_next = {rb_chan(f_addr), `DDC_SEL_IN_SPAN};
            `DDC_CMD_WR_CODE: ptr_next = {rb_chan(f_addr), `DDC_SEL_IN_CODE};
            `DDC_CMD_UPD_N: ptr_next = {rb_chan(f_addr), `DDC_SEL_ACT_SPAN};
            `DDC_CMD_WRS_UPD_N, `DDC_CMD_WRS_UPD_ALL: ptr_next = {rb_chan(f_addr), `DDC_SEL_ACT_SPAN};
            `DDC_CMD_UPD_ALL, `DDC_CMD_NOP: ptr_next = {rb_chan(f_addr), `DDC_SEL_ACT_CODE};
            `DDC_CMD_WRC_UPD_N, `DDC_CMD_WRC_UPD_ALL: ptr_next = {rb_chan(f_addr), `DDC_SEL_ACT_CODE};
            default: ptr_set = 1'b0; // reads already set it; reserved codes leave it
        endcase
    end

    // reads move the pointer at the header so the same word returns it
    always @(posedge clk_i)
    begin
        if (rst_i || !clr_n_s)
        begin
            ptr_reg <= `DDC_PTR_RESET;
        end
        else if (hdr_done && hdr_read)
        begin
            ptr_reg <= rd_ptr;
        end
        else if (frame_ok && ptr_set)
        begin
            ptr_reg <= ptr_next;
        end
    end

    // ****************************************************************
    // readback output
    // ****************************************************************

    wire [2:0] load_ptr = hdr_read ? rd_ptr : ptr_reg;
    wire [DW-1:0] load_word = rb_pick(load_ptr, in_span_w, in_code_w, act_span_rd, act_code_w);

    // the word is captured on the last address edge and leaves on the
    // following falls; until then the pin reads low
    ddc_rb_shift #(
        .W(DW)
    ) u_rb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .idle_i(!in_frame),
        .load_i(hdr_done),
        .data_i(load_word),
        .shift_i(sck_fall),
        .bit_o(readback_serial_out_o)
    );

    // pin is released whenever select is high
    assign readback_serial_oe_o = ~cs_n_s;

    assign act_code_a_o = act_code_w[DW-1:0];
    assign act_code_b_o = act_code_w[2*DW-1:DW];
    assign act_span_a_o = act_span_rd[SW-1:0];
    assign act_span_b_o = act_span_rd[2*SW-1:SW];

endmodule

// [inc/ddc_defs.vh]
// constants for the dual dac serial command decoder and readback logic
`ifndef DDC_DEFS_VH
`define DDC_DEFS_VH

// ****************************************************************
// command field codes
// ****************************************************************
`define DDC_CMD_WR_SPAN 4'h2
`define DDC_CMD_WR_CODE 4'h3
`define DDC_CMD_UPD_N 4'h4
`define DDC_CMD_UPD_ALL 4'h5
`define DDC_CMD_WRS_UPD_N 4'h6
`define DDC_CMD_WRC_UPD_N 4'h7
`define DDC_CMD_WRS_UPD_ALL 4'h8
`define DDC_CMD_WRC_UPD_ALL 4'h9
`define DDC_CMD_RD_IN_SPAN 4'ha
`define DDC_CMD_RD_IN_CODE 4'hb
`define DDC_CMD_RD_ACT_SPAN 4'hc
`define DDC_CMD_RD_ACT_CODE 4'hd
`define DDC_CMD_NOP 4'hf

// ****************************************************************
// address field (upper three bits, lowest bit ignored)
// ****************************************************************
`define DDC_ADDR_A 3'h0
`define DDC_ADDR_B 3'h1
`define DDC_ADDR_ALL 3'h7

// ****************************************************************
// readback pointer: {channel, buffer select}
// ****************************************************************
`define DDC_SEL_IN_SPAN 2'h0
`define DDC_SEL_IN_CODE 2'h1
`define DDC_SEL_ACT_SPAN 2'h2
`define DDC_SEL_ACT_CODE 2'h3
`define DDC_RD_SEL_FLIP 2'h2
`define DDC_PTR_RESET 3'h2

// ****************************************************************
// frame layout
// ****************************************************************
`define DDC_HDR_BITS 6'h08
`define DDC_LONG_HDR_BITS 6'h10
`define DDC_SHORT_FRAME_BITS 6'h18
`define DDC_LONG_FRAME_BITS 6'h20
`define DDC_CNT_MAX 6'h3f

// ****************************************************************
// span codes
// ****************************************************************
`define DDC_SPAN_UNI_5 4'h0
`define DDC_SPAN_UNI_10 4'h1
`define DDC_SPAN_BI_5 4'h2
`define DDC_SPAN_BI_10 4'h3
`define DDC_SPAN_BI_2P5 4'h4
`define DDC_SPAN_OFS_2P5 4'h5

`endif

// [hdl/ddc_sync2.v]
// two flip-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ps
module ddc_sync2 #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input wire clk_i,          // system clock
    input wire rst_i,          // synchronous reset, active high
    input wire [W-1:0] d_i,    // asynchronous levels
    output wire [W-1:0] q_o    // synchronised levels
);

    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    // first stage feeds only the second stage
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end
        else
        begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
        end
    end

    assign q_o = sync_reg;

endmodule

// [hdl/ddc_rb_shift.v]
// readback shift register that drives the serial readback bit
`timescale 1ns/1ps
module ddc_rb_shift #(
    parameter W = 16
) (
    input wire clk_i,          // system clock
    input wire rst_i,          // synchronous reset, active high
    input wire idle_i,         // frame inactive, empties the register
    input wire load_i,         // capture a readback word
    input wire [W-1:0] data_i, // word to shift out
    input wire shift_i,        // falling link edge, present next bit
    output reg bit_o           // current readback bit
);

    reg [W-1:0] sh_reg;

    // zeros fill behind the word, so the pin stays low once it is out
    always @(posedge clk_i)
    begin
        if (rst_i || idle_i)
        begin
            sh_reg <= {W{1'b0}};
            bit_o <= 1'b0;
        end
        else if (load_i)
        begin
            sh_reg <= data_i;
        end
        else if (shift_i)
        begin
            bit_o <= sh_reg[W-1];
            sh_reg <= {sh_reg[W-2:0], 1'b0};
        end
    end

endmodule

// [verif/ddc_props.sv]
// port-level checks for the dual dac command decoder
`timescale 1ns/1ps
module ddc_props #(
    parameter DW = 16,
    parameter SW = 4
) (
    input wire clk_i,                   // clock
    input wire rst_i,                   // reset
    input wire link_clk_i,              // link clock
    input wire serial_in_i,             // serial data
    input wire select_and_load_n_i,     // frame select
    input wire async_update_n_i,        // update pin
    input wire clear_n_i,               // clear pin
    input wire manual_span_i,           // strap mode
    input wire span_strap_bit2_i,       // strap 2
    input wire span_strap_bit1_i,       // strap 1
    input wire span_strap_bit0_i,       // strap 0
    input wire readback_serial_out_o,   // readback bit
    input wire readback_serial_oe_o,    // readback drive
    input wire [DW-1:0] act_code_a_o,   // code a
    input wire [DW-1:0] act_code_b_o,   // code b
    input wire [SW-1:0] act_span_a_o,   // span a
    input wire [SW-1:0] act_span_b_o,   // span b
    input wire [1:0] span_bipolar_o,    // bipolar flags
    input wire [1:0] span_legal_o       // legal flags
);
    // ********
    // assertions
    // ********
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    oe_frame_a: assert property (!select_and_load_n_i [*4] |-> readback_serial_oe_o)
        else $error("readback pin not driven in frame");
    oe_idle_a: assert property (select_and_load_n_i [*4] |-> !readback_serial_oe_o)
        else $error("readback pin driven outside frame");
    out_idle_a: assert property (!readback_serial_oe_o |-> !readback_serial_out_o)
        else $error("readback bit high outside frame");
    out_header_a: assert property ($rose(readback_serial_oe_o) |-> !readback_serial_out_o [*8])
        else $error("readback bit high during header");
    out_on_fall_a: assert property (readback_serial_oe_o && $changed(readback_serial_out_o) |-> !link_clk_i)
        else $error("readback bit moved on rising link edge");
    // a short clear pulse mid-frame zeroes the codes three cycles later, so demand clear high now and three cycles back
    code_hold_a: assert property (readback_serial_oe_o && $past(readback_serial_oe_o) && clear_n_i
        && $past(clear_n_i, 3) |-> $stable(act_code_a_o) && $stable(act_code_b_o))
        else $error("active code changed inside frame");
    span_dec_a: assert property (span_bipolar_o[0] == (act_span_a_o >= 4'h2 && act_span_a_o <= 4'h5)
        && span_legal_o[0] == (act_span_a_o <= 4'h5)) else $error("span a decode wrong");
    span_b_dec_a: assert property (span_bipolar_o[1] == (act_span_b_o >= 4'h2 && act_span_b_o <= 4'h5)
        && span_legal_o[1] == (act_span_b_o <= 4'h5)) else $error("span b decode wrong");
    strap_span_a: assert property ((manual_span_i && $stable({span_strap_bit2_i, span_strap_bit1_i,
        span_strap_bit0_i})) [*5] |-> act_span_a_o == {1'b0, span_strap_bit2_i, span_strap_bit1_i,
        span_strap_bit0_i}) else $error("strap span not in force");
    clear_act_a: assert property (!clear_n_i [*4] |-> act_code_a_o == '0 && act_code_b_o == '0)
        else $error("clear left active code");
    cover property ($fell(async_update_n_i) && select_and_load_n_i);
    cover property ($rose(readback_serial_oe_o));
    cover property (manual_span_i && readback_serial_oe_o);
    cover property (!clear_n_i [*4]);
endmodule
bind ddc_cmd_readback ddc_props #(.DW(DW), .SW(SW)) u_props (.clk_i(clk_i), .rst_i(rst_i),
    .link_clk_i(link_clk_i), .serial_in_i(serial_in_i), .select_and_load_n_i(select_and_load_n_i),
    .async_update_n_i(async_update_n_i), .clear_n_i(clear_n_i), .manual_span_i(manual_span_i),
    .span_strap_bit2_i(span_strap_bit2_i), .span_strap_bit1_i(span_strap_bit1_i),
    .span_strap_bit0_i(span_strap_bit0_i), .readback_serial_out_o(readback_serial_out_o),
    .readback_serial_oe_o(readback_serial_oe_o), .act_code_a_o(act_code_a_o), .act_code_b_o(act_code_b_o),
    .act_span_a_o(act_span_a_o), .act_span_b_o(act_span_b_o), .span_bipolar_o(span_bipolar_o),
    .span_legal_o(span_legal_o));

// [verif/ddc_host_model.sv]
// serial host model that clocks command frames and captures readback
`timescale 1ns/1ps
module ddc_host_model (
    input wire logic clk_i,      // system clock
    input wire logic sro_i,      // readback bit
    output logic link_clk_o,     // link clock, still between frames
    output logic sdi_o,          // serial data
    output logic sel_n_o,        // frame select
    output logic done_o,         // word captured
    output logic [15:0] word_o   // captured readback
);
    // idle levels
    initial
    begin
        link_clk_o = 1'b0;
        sdi_o = 1'b0;
        sel_n_o = 1'b1;
        done_o = 1'b0;
        word_o = 16'h0000;
    end
    // one frame msb first; the 11 ns offset keeps link edges off the system clock
    task frame(input logic [23:0] w, input logic lf);
        logic [31:0] bits;
        int n;
        bits = lf ? {8'h00, w} : {w, 8'h00};
        n = lf ? 32 : 24;
        @(negedge clk_i);
        #11 sel_n_o = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            sdi_o = bits[31-i];
            #200 link_clk_o = 1'b1;
            if (i >= n - 16)
                word_o = {word_o[14:0], sro_i};
            #200 link_clk_o = 1'b0;
        end
        #200 sel_n_o = 1'b1;
        sdi_o = ~sdi_o;  // released line does not keep its last value
        #400 done_o = 1'b1;
        #50 done_o = 1'b0;
    endtask
endmodule

// [verif/dual_dac_serial_cmd_readback_test.sv]
// self-checking bench for the dual dac command decoder and readback
`timescale 1ns/1ps
`include "ddc_defs.vh"
`define CHK(G, X) begin compares++; if ((G) !== (X)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, G, X); end end
module dual_dac_serial_cmd_readback_test;
    logic clk, rst, lclk, sdi, seln, upd_n, clr_n, man, done, readback_serial_out, oe;
    logic [2:0] st;
    logic [15:0] ca, cb, word, exp_w, dat;
    logic [3:0] sa, sb, cmd;
    logic [1:0] bip, leg;
    logic [15:0] ic [2];
    logic [15:0] ac [2];
    logic [3:0] is [2];
    logic [3:0] as [2];
    logic [2:0] ptr;
    logic [15:0] expq [$];
    logic [3:0] cmds [13] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'hf};
    logic [2:0] adr [3] = '{`DDC_ADDR_A, `DDC_ADDR_B, `DDC_ADDR_ALL};
    int n_fail, compares, cyc;
    ddc_cmd_readback u_dut (.clk_i(clk), .rst_i(rst), .link_clk_i(lclk), .serial_in_i(sdi),
        .select_and_load_n_i(seln), .async_update_n_i(upd_n), .clear_n_i(clr_n), .manual_span_i(man),
        .span_strap_bit2_i(st[2]), .span_strap_bit1_i(st[1]), .span_strap_bit0_i(st[0]),
        .readback_serial_out_o(readback_serial_out), .readback_serial_oe_o(oe), .act_code_a_o(ca), .act_code_b_o(cb),
        .act_span_a_o(sa), .act_span_b_o(sb), .span_bipolar_o(bip), .span_legal_o(leg));
    ddc_host_model u_host (.clk_i(clk), .sro_i(readback_serial_out), .link_clk_o(lclk), .sdi_o(sdi), .sel_n_o(seln),
        .done_o(done), .word_o(word));
    // ********
    // reference model
    // ********
    function automatic logic [15:0] rbv(input logic c, input logic [1:0] s);
        case (s)
            2'h0: rbv = {12'h000, is[c]};
            2'h1: rbv = ic[c];
            2'h2: rbv = {12'h000, man ? {1'b0, st} : as[c]};
            default: rbv = ac[c];
        endcase
    endfunction
    task upd(input logic [1:0] m);
        for (int k = 0; k < 2; k++)
        begin
            if (m[k])
            begin
                as[k] = is[k];
                ac[k] = ic[k];
            end
        end
    endtask
    task chk_act;
        logic [3:0] e [2];
        for (int k = 0; k < 2; k++)
            e[k] = man ? {1'b0, st} : as[k];
        `CHK(ca, ac[0])
        `CHK(cb, ac[1])
        `CHK(sa, e[0])
        `CHK(sb, e[1])
        for (int k = 0; k < 2; k++)
        begin
            `CHK(bip[k], e[k] >= 4'h2 && e[k] <= 4'h5)
            `CHK(leg[k], e[k] <= 4'h5)
        end
    endtask
    // one frame: note the expected readback, run it, then advance the model
    task send(input logic [3:0] cm, input logic [3:0] a, input logic [15:0] d, input logic lf, input logic lk);
        logic c;
        logic [1:0] m;
        c = (a[3:1] == `DDC_ADDR_B);
        m = (a[3:1] == `DDC_ADDR_ALL) ? 2'h3 : (c ? 2'h2 : 2'h1);
        if (cm >= 4'ha && cm <= 4'hd)
            ptr = {c, 2'(cm - 4'ha)};
        expq.push_back(rbv(ptr[2], ptr[1:0]));
        fork
            u_host.frame({cm, a, d}, lf);
            if (lk)
            begin
                #3000 upd_n = 1'b0;
                #500 upd_n = 1'b1;
            end
        join
        for (int k = 0; k < 2; k++)
        begin
            if (m[k] && cm inside {4'h2, 4'h6, 4'h8})
                is[k] = d[3:0];
            if (m[k] && cm inside {4'h3, 4'h7, 4'h9})
                ic[k] = d;
        end
        if (cm inside {4'h4, 4'h6, 4'h7})
            upd(m);
        if (cm inside {4'h5, 4'h8, 4'h9})
            upd(2'h3);
        if (cm inside {4'h2, 4'h3})
            ptr = {c, 1'b0, cm[0]};
        if (cm inside {4'h4, 4'h6, 4'h8})
            ptr = {c, `DDC_SEL_ACT_SPAN};
        if (cm inside {4'h5, 4'h7, 4'h9, 4'hf})
            ptr = {c, `DDC_SEL_ACT_CODE};
        chk_act();
    endtask
    // ********
    // clock, checking and closing
    // ********
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // each captured readback word meets the oldest note
    always @(posedge done)
    begin
        exp_w = expq.pop_front();
        `CHK(word, exp_w)
    end
    // hang guard, well above the roughly 21000 cycles the sequence needs
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            n_fail++;
            results();
        end
    end
    task results;
        if (n_fail == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // main sequence: reset pointer, every span code, then every command and random traffic
    initial
    begin
        {rst, upd_n, clr_n, man, st} = 7'h70;
        {n_fail, compares, cyc} = 0;
        ic = '{16'h0000, 16'h0000};
        ac = '{16'h0000, 16'h0000};
        is = '{4'h0, 4'h0};
        as = '{4'h0, 4'h0};
        ptr = `DDC_PTR_RESET;
        void'($urandom(18));
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        send(4'hf, 4'h0, 16'h0000, 1'b0, 1'b0);
        for (int s = 0; s < 6; s++)
            send(4'h6, 4'h2, 16'(s), 1'(s), 1'b0);
        for (int i = 0; i < 80; i++)
        begin
            cmd = i < 13 ? cmds[i] : cmds[$urandom % 13];
            man = ($urandom % 4) == 0;
            st = 3'($urandom);
            dat = cmd inside {4'h2, 4'h6, 4'h8} ? 16'($urandom % 6) : 16'($urandom);
            send(cmd, {adr[$urandom % 3], 1'($urandom)}, dat, 1'($urandom), ($urandom % 4) == 0);
            if ($urandom % 6 == 0)
            begin
                @(negedge clk);
                upd_n = 1'b0;
                repeat (3) @(negedge clk);
                upd_n = 1'b1;
                repeat (4) @(negedge clk);
                upd(2'h3);
                chk_act();
            end
            if ($urandom % 8 == 0)
            begin
                @(negedge clk);
                clr_n = 1'b0;
                repeat (4) @(negedge clk);
                clr_n = 1'b1;
                repeat (4) @(negedge clk);
                ac = '{16'h0000, 16'h0000};
                as = '{4'h0, 4'h0};
                ptr = `DDC_PTR_RESET;
                chk_act();
            end
        end
        results();
    end
endmodule
